/* ospc_config.sv */
/*
  Register slice for output pair three source select, output divider
  synchronisation and analog PLL loop settings.
  Assumes a synchronous 8-bit register port on clk: one-cycle strobes,
  never read and write together, read data valid the cycle after.
*/
// The address-and-strobe port is this design's own decision.

`timescale 1ns/1ps
`default_nettype none

module ospc_config #(
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic out_div_hold,
  output logic out_div_hold_start,
  output logic out_div_release,
  output logic [1:0] out_pair_three_source_select,
  output logic out_src_pll,
  output logic out_src_input_ref_zero,
  output logic out_src_input_ref_one,
  output logic out_src_crystal,
  output logic [2:0] loop_series_resistor,
  output logic [10:0] loop_series_ohm,
  output logic [1:0] second_pole_setting,
  output logic [7:0] second_pole_pf,
  output logic second_pole_bypass,
  output logic time_digitizer_disable,
  output logic synth_only_mode,
  output logic lock_counter_width,
  output logic [4:0] lock_counter_bits,
  output logic lock_override_mode,
  output logic [2:0] manual_vco_select,
  output logic manual_vco_code_valid,
  output logic manual_vco_second,
  output logic [4:0] manual_lock_code,
  output logic [4:0] pump_current_select,
  output logic [11:0] pump_current_ua
);

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] rel;
  logic hit;
  logic [3:0] idx;

  assign base = ADDR_W'(ospc_pkg::OSPC_OFS_SYNC_SRC);
  assign rel = addr - base;
  assign hit = (addr >= base) &&
               (rel < ADDR_W'(ospc_pkg::OSPC_NUM_REGS));
  assign idx = rel[3:0];

  function automatic logic [7:0] rst_val(input int i);
    logic [7:0] v;
    v = ospc_pkg::OSPC_RST_SPARE;
    case (i)
      0: v = ospc_pkg::OSPC_RST_SYNC_SRC;
      4: v = ospc_pkg::OSPC_RST_FIXED;
      5: v = ospc_pkg::OSPC_RST_LOOP_FILT;
      6: v = ospc_pkg::OSPC_RST_MODE_LOCK;
      7: v = ospc_pkg::OSPC_RST_MAN_VCO;
      8: v = ospc_pkg::OSPC_RST_PLL_SPARE;
      9: v = ospc_pkg::OSPC_RST_PUMP;
      default: v = ospc_pkg::OSPC_RST_SPARE;
    endcase
    return v;
  endfunction : rst_val

  // ---------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------
  // Every byte holds what was written, reserved positions included, so
  // reserved reads return whatever software put there.
  logic [7:0] regs_q [ospc_pkg::OSPC_NUM_REGS];
  logic [7:0] regs_d [ospc_pkg::OSPC_NUM_REGS];
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;

  always_comb begin
    for (int i = 0; i < ospc_pkg::OSPC_NUM_REGS; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (wr_en && hit) begin
      regs_d[idx] = wr_data; // [R18] [R5]
    end
    rd_data_d = 8'h00;
    if (rd_en && hit) begin
      rd_data_d = regs_q[idx]; // [R18]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < ospc_pkg::OSPC_NUM_REGS; i++) begin
        regs_q[i] <= rst_val(i);
      end
      rd_data_q <= 8'h00;
    end else begin
      for (int i = 0; i < ospc_pkg::OSPC_NUM_REGS; i++) begin
        regs_q[i] <= regs_d[i];
      end
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data = rd_data_q;

  // ---------------------------------------------------------------------
  // Output divider synchronisation
  // ---------------------------------------------------------------------
  // Edges come from the stored bit, so rewriting the same value leaves
  // the dividers alone.
  logic sync_bit;
  logic sync_prev_q;
  logic sync_prev_d;
  logic hold_start_q;
  logic hold_start_d;
  logic release_q;
  logic release_d;

  assign sync_bit = regs_q[0][ospc_pkg::OSPC_BIT_SYNC];

  always_comb begin
    sync_prev_d = sync_bit;
    hold_start_d = sync_bit && !sync_prev_q; // [R17] [R1]
    release_d = !sync_bit && sync_prev_q; // [R17] [R2]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sync_prev_q <= 1'b0;
      hold_start_q <= 1'b0;
      release_q <= 1'b0;
    end else begin
      sync_prev_q <= sync_prev_d;
      hold_start_q <= hold_start_d;
      release_q <= release_d;
    end
  end

  // One shared hold level for every divider, so all leave reset together
  assign out_div_hold = sync_bit; // [R1] [R2]
  assign out_div_hold_start = hold_start_q;
  assign out_div_release = release_q; // [R2]

  // ---------------------------------------------------------------------
  // Source select for output pair three
  // ---------------------------------------------------------------------
  ospc_pkg::ospc_src_t src_sel;

  assign src_sel = ospc_pkg::ospc_src_t'(
    regs_q[0][ospc_pkg::OSPC_POS_SRC_SEL +: 2]);
  assign out_pair_three_source_select = src_sel; // [R3]

  // A direct reference route is only safe below the reference limit,
  // which software has to respect; nothing here checks frequency. [R4]
  always_comb begin
    out_src_pll = 1'b0;
    out_src_input_ref_zero = 1'b0;
    out_src_input_ref_one = 1'b0;
    out_src_crystal = 1'b0;
    case (src_sel) // [R3]
      ospc_pkg::OSPC_SRC_PLL: out_src_pll = 1'b1;
      ospc_pkg::OSPC_SRC_REF_ZERO: out_src_input_ref_zero = 1'b1;
      ospc_pkg::OSPC_SRC_REF_ONE: out_src_input_ref_one = 1'b1;
      ospc_pkg::OSPC_SRC_CRYSTAL: out_src_crystal = 1'b1;
      default: out_src_pll = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------------
  // Loop filter settings
  // ---------------------------------------------------------------------
  assign loop_series_resistor =
    regs_q[5][ospc_pkg::OSPC_POS_RES +: 3]; // [R6]
  assign loop_series_ohm =
    ospc_pkg::ospc_res_ohm(loop_series_resistor); // [R6]
  assign second_pole_setting =
    regs_q[5][ospc_pkg::OSPC_POS_POLE +: 2]; // [R7]
  assign second_pole_pf =
    ospc_pkg::ospc_pole_pf(second_pole_setting); // [R7]
  assign second_pole_bypass =
    regs_q[5][ospc_pkg::OSPC_BIT_POLE_BYP]; // [R8]

  // ---------------------------------------------------------------------
  // Mode and lock control
  // ---------------------------------------------------------------------
  assign time_digitizer_disable =
    regs_q[6][ospc_pkg::OSPC_BIT_TIME_DIGITIZER_DISABLE]; // [R9]
  // Free-run forcing lives in another block; software sets it first.
  assign synth_only_mode = regs_q[6][ospc_pkg::OSPC_BIT_SYNTH]; // [R10]
  assign lock_counter_width =
    regs_q[6][ospc_pkg::OSPC_BIT_CNT_WIDTH]; // [R12]
  assign lock_counter_bits = lock_counter_width ?
    ospc_pkg::OSPC_CNT_WIDE : ospc_pkg::OSPC_CNT_NARROW; // [R12]
  assign lock_override_mode =
    regs_q[6][ospc_pkg::OSPC_BIT_LOCK_OVR]; // [R13]

  // ---------------------------------------------------------------------
  // Manual lock values and pump current
  // ---------------------------------------------------------------------
  assign manual_vco_select =
    regs_q[7][ospc_pkg::OSPC_POS_VCO_SEL +: 3]; // [R14]
  assign manual_vco_code_valid =
    manual_vco_select <= ospc_pkg::OSPC_VCO_MAX; // [R14]
  assign manual_vco_second = manual_vco_select[0] &&
    manual_vco_code_valid; // [R14]
  assign manual_lock_code =
    regs_q[7][ospc_pkg::OSPC_POS_LOCK_CODE +: 5]; // [R15]
  assign pump_current_select =
    regs_q[9][ospc_pkg::OSPC_POS_PUMP +: 5]; // [R16]
  assign pump_current_ua =
    ospc_pkg::ospc_pump_ua(pump_current_select); // [R16]

endmodule : ospc_config

`default_nettype wire

/* ospc_config_props.sv */
/* Concurrent checks on the ports of ospc_config.
   Assumes one clock, synchronous active-high reset, bound below. */
`timescale 1ns/1ps
`default_nettype none
module ospc_config_props #(
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic out_div_hold,
  input wire logic out_div_hold_start,
  input wire logic out_div_release,
  input wire logic [1:0] out_pair_three_source_select,
  input wire logic out_src_pll,
  input wire logic out_src_input_ref_zero,
  input wire logic out_src_input_ref_one,
  input wire logic out_src_crystal,
  input wire logic [2:0] loop_series_resistor,
  input wire logic lock_counter_width,
  input wire logic [4:0] lock_counter_bits,
  input wire logic [4:0] pump_current_select,
  input wire logic [11:0] pump_current_ua
);
  // ---------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------
  logic [7:0] wd_q;
  always_ff @(posedge clk) begin
    wd_q <= wr_data;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_hold_set;
    wr_en && addr == ADDR_W'(ospc_pkg::OSPC_OFS_SYNC_SRC)
      |=> out_div_hold == wd_q[7];
  endproperty
  a_hold_set: assert property (p_hold_set)
    else $error("hold does not follow written sync bit");
  property p_start;
    $rose(out_div_hold) |=> out_div_hold_start ##1 !out_div_hold_start;
  endproperty
  a_start: assert property (p_start)
    else $error("hold start pulse wrong");
  property p_release;
    $fell(out_div_hold) |=> out_div_release ##1 !out_div_release;
  endproperty
  a_release: assert property (p_release)
    else $error("release pulse wrong");
  property p_no_spurious;
    out_div_hold_start || out_div_release
      |-> $past(out_div_hold) != $past(out_div_hold, 2);
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("pulse without sync change");
  property p_src;
    {out_src_crystal, out_src_input_ref_one, out_src_input_ref_zero,
     out_src_pll} == 4'h1 << out_pair_three_source_select;
  endproperty
  a_src: assert property (p_src)
    else $error("source decode wrong");
  property p_res;
    wr_en && addr == ADDR_W'(ospc_pkg::OSPC_OFS_LOOP_FILT)
      |=> loop_series_resistor == wd_q[5:3];
  endproperty
  a_res: assert property (p_res)
    else $error("resistor field not updated");
  property p_cnt;
    lock_counter_bits == (lock_counter_width ? 5'h14 : 5'h10);
  endproperty
  a_cnt: assert property (p_cnt)
    else $error("counter width wrong");
  property p_pump;
    pump_current_ua == (pump_current_select[4] ? 12'd165 : 12'd110)
      * ({8'h00, pump_current_select[3:0]} + 12'h001);
  endproperty
  a_pump: assert property (p_pump)
    else $error("pump current wrong");
  property p_rd_idle;
    !rd_en |=> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
endmodule : ospc_config_props
bind ospc_config ospc_config_props #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire

/* ospc_pkg.sv */
/*
  Constants for the output source and analog PLL configuration slice:
  register offsets, field positions, reset values and lookup tables.
  Assumes an 8-bit register port with byte addresses from 0x63 up.
*/

// Notes on behaviour
// (R1) Sync bit rising holds all output dividers
// (R2) Sync bit falling releases all dividers together
// (R3) Two-bit source select for pair three
// (R4) Software avoids fast references on pair three
// (R5) Reserved bits written zero, read undefined
// (R6) Three-bit series resistor select, resets 001
// (R7) Two-bit second-pole capacitance, resets 01
// (R8) Second-pole bypass bit, resets to bypassed
// (R9) Time digitizer disable bit, resets zero
// (R10) Synth-only mode uses crystal alone
// (R11) Software forces free-run before synth-only mode
// (R12) Lock counter width 16 or 20 bits
// (R13) Lock override chooses automatic or manual
// (R14) Manual VCO select, codes above 001 reserved
// (R15) Five-bit manual lock code, resets 01011
// (R16) Five-bit pump current select, resets zero
// (R17) Sync edges detected from stored value
// (R18) Fields read back last written value

package ospc_pkg;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [15:0] OSPC_OFS_SYNC_SRC = 16'h0063;
  localparam logic [15:0] OSPC_OFS_SPARE_A = 16'h0064;
  localparam logic [15:0] OSPC_OFS_SPARE_B = 16'h0065;
  localparam logic [15:0] OSPC_OFS_SPARE_C = 16'h0066;
  localparam logic [15:0] OSPC_OFS_FIXED = 16'h0067;
  localparam logic [15:0] OSPC_OFS_LOOP_FILT = 16'h0068;
  localparam logic [15:0] OSPC_OFS_MODE_LOCK = 16'h0069;
  localparam logic [15:0] OSPC_OFS_MAN_VCO = 16'h006A;
  localparam logic [15:0] OSPC_OFS_PLL_SPARE = 16'h006B;
  localparam logic [15:0] OSPC_OFS_PUMP = 16'h006C;
  localparam int OSPC_NUM_REGS = 10;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] OSPC_RST_SYNC_SRC = 8'h00;
  localparam logic [7:0] OSPC_RST_SPARE = 8'h00;
  localparam logic [7:0] OSPC_RST_FIXED = 8'hA0;
  localparam logic [7:0] OSPC_RST_LOOP_FILT = 8'h0B;
  localparam logic [7:0] OSPC_RST_MODE_LOCK = 8'h06;
  localparam logic [7:0] OSPC_RST_MAN_VCO = 8'h2B;
  localparam logic [7:0] OSPC_RST_PLL_SPARE = 8'h20;
  localparam logic [7:0] OSPC_RST_PUMP = 8'h00;

  // ---------------------------------------------------------------------
  // Field positions (lowest bit of each field)
  // ---------------------------------------------------------------------
  localparam int OSPC_BIT_SYNC = 7;
  localparam int OSPC_POS_SRC_SEL = 2;
  localparam int OSPC_POS_RES = 3;
  localparam int OSPC_POS_POLE = 1;
  localparam int OSPC_BIT_POLE_BYP = 0;
  localparam int OSPC_BIT_TIME_DIGITIZER_DISABLE = 4;
  localparam int OSPC_BIT_SYNTH = 3;
  localparam int OSPC_BIT_CNT_WIDTH = 1;
  localparam int OSPC_BIT_LOCK_OVR = 0;
  localparam int OSPC_POS_VCO_SEL = 5;
  localparam int OSPC_POS_LOCK_CODE = 0;
  localparam int OSPC_POS_PUMP = 0;

  // Highest manual VCO code that is not reserved
  localparam logic [2:0] OSPC_VCO_MAX = 3'h1;
  // Accumulator widths of the digital lock counter
  localparam logic [4:0] OSPC_CNT_NARROW = 5'h10;
  localparam logic [4:0] OSPC_CNT_WIDE = 5'h14;

  // ---------------------------------------------------------------------
  // Source choices for output pair three
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    OSPC_SRC_PLL = 2'h0,
    OSPC_SRC_REF_ZERO = 2'h1,
    OSPC_SRC_REF_ONE = 2'h2,
    OSPC_SRC_CRYSTAL = 2'h3
  } ospc_src_t;

  // ---------------------------------------------------------------------
  // Lookup tables: series resistor in ohms, pole capacitance in pF,
  // pump current in microamps
  // ---------------------------------------------------------------------
  function automatic logic [10:0] ospc_res_ohm(input logic [2:0] code);
    logic [10:0] r;
    r = 11'h000;
    case (code)
      3'h0: r = 11'd98;
      3'h1: r = 11'd107;
      3'h2: r = 11'd131;
      3'h3: r = 11'd168;
      3'h4: r = 11'd235;
      3'h5: r = 11'd294;
      3'h6: r = 11'd588;
      default: r = 11'd1180;
    endcase
    return r;
  endfunction : ospc_res_ohm

  function automatic logic [7:0] ospc_pole_pf(input logic [1:0] code);
    logic [7:0] c;
    c = 8'h00;
    case (code)
      2'h0: c = 8'd120;
      2'h1: c = 8'd160;
      2'h2: c = 8'd200;
      default: c = 8'd240;
    endcase
    return c;
  endfunction : ospc_pole_pf

  // Lower half steps by 110 uA from 110, upper half by 165 uA from 165
  function automatic logic [11:0] ospc_pump_ua(input logic [4:0] code);
    logic [11:0] step;
    logic [11:0] idx;
    step = code[4] ? 12'd165 : 12'd110;
    idx = {8'h00, code[3:0]} + 12'h001;
    return 12'(step * idx);
  endfunction : ospc_pump_ua

endpackage : ospc_pkg

/* ospc_tb.sv */
/* Self-checking bench for ospc_config.
   Assumes the package ospc_pkg and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("Error %0t: got %0h expected %0h", $time, a, e); end end
module testbench;
  // ---------------------------------------------------------------------
  // Stimulus and checks
  // ---------------------------------------------------------------------
  logic clk, reset, wr_en, rd_en, hold, hs, rel, p0, p1, p2, p3, byp;
  logic tdc, syn, cw, ovr, vv, v2;
  logic [15:0] addr;
  logic [7:0] wr_data, rd_data, pf, r;
  logic [1:0] sel, pole;
  logic [2:0] res, vco;
  logic [10:0] ohm;
  logic [4:0] cbits, code, pump;
  logic [11:0] ua;
  int num_errors = 0, num_checks = 0, cyc = 0, i;
  int otab[8] = '{98, 107, 131, 168, 235, 294, 588, 1180};
  ospc_config u_dut (.clk, .reset, .addr, .wr_data, .wr_en, .rd_en,
    .rd_data, .out_div_hold(hold), .out_div_hold_start(hs),
    .out_div_release(rel), .out_pair_three_source_select(sel),
    .out_src_pll(p0), .out_src_input_ref_zero(p1),
    .out_src_input_ref_one(p2), .out_src_crystal(p3),
    .loop_series_resistor(res), .loop_series_ohm(ohm),
    .second_pole_setting(pole), .second_pole_pf(pf),
    .second_pole_bypass(byp), .time_digitizer_disable(tdc),
    .synth_only_mode(syn), .lock_counter_width(cw),
    .lock_counter_bits(cbits), .lock_override_mode(ovr),
    .manual_vco_select(vco), .manual_vco_code_valid(vv),
    .manual_vco_second(v2), .manual_lock_code(code),
    .pump_current_select(pump), .pump_current_ua(ua));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    `CHK(rd_data, e)
  endtask : rd_chk
  task automatic t_reset;
    rd_chk(16'h0063, 8'h00);
    rd_chk(16'h0068, 8'h0B);
    rd_chk(16'h0069, 8'h06);
    rd_chk(16'h006A, 8'h2B);
    rd_chk(16'h006C, 8'h00);
    rd_chk(16'h0064, 8'h00);
    rd_chk(16'h0067, 8'hA0);
    rd_chk(16'h006B, 8'h20);
    `CHK({p0, byp, tdc, syn, cbits}, 9'h194)
    `CHK({hold, hs, rel}, 3'h0)
    $display("test reset values done");
  endtask : t_reset
  task automatic t_fields;
    for (i = 0; i < 32; i++) begin
      if (i < 4) begin
        wr(16'h0063, 8'(i << 2));
        #1 `CHK({p3, p2, p1, p0}, 4'(1 << i))
        `CHK(sel, 2'(i))
      end
      if (i < 8) begin
        r = {2'h0, 3'(i), 2'(i), 1'(i)};
        wr(16'h0068, r);
        #1 `CHK({res, pole, byp}, r[5:0])
        `CHK(ohm, 11'(otab[i]))
        `CHK(pf, 8'(120 + 40 * (i % 4)))
        rd_chk(16'h0068, r);
      end
      if (i < 16) begin
        wr(16'h0069, {3'h0, 2'(i >> 2), 1'b1, 2'(i)});
        #1 `CHK({tdc, syn, cw, ovr}, 4'(i))
        `CHK(cbits, i[1] ? 5'h14 : 5'h10)
      end
      wr(16'h006A, {3'(i), 5'(i)});
      #1 `CHK({vco, code}, {3'(i), 5'(i)})
      `CHK({vv, v2}, {i % 8 < 2, i % 8 == 1})
      wr(16'h006C, 8'(i));
      #1 `CHK(pump, 5'(i))
      `CHK(ua, 12'((i > 15 ? 165 : 110) * (i % 16 + 1)))
    end
    $display("test fields done");
  endtask : t_fields
  task automatic t_sync;
    for (i = 0; i < 4; i++) begin
      wr(16'h0063, {i[1], 7'h00});
      #1 `CHK({hold, hs, rel}, {i[1], 2'h0})
      @(posedge clk);
      #1 `CHK({hs, rel}, {i == 2, 1'b0})
    end
    wr(16'h0063, 8'h00);
    #1 `CHK({hold, rel}, 2'h0)
    @(posedge clk);
    #1 `CHK(rel, 1'b1)
    @(posedge clk);
    #1 `CHK(rel, 1'b0)
    $display("test sync done");
  endtask : t_sync
  task automatic t_unmapped;
    wr(16'h0063, 8'h0C);
    wr(16'h0062, 8'hFF);
    wr(16'h006D, 8'hFF);
    rd_chk(16'h006D, 8'h00);
    rd_chk(16'h0063, 8'h0C);
    $display("test unmapped done");
  endtask : t_unmapped
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    reset = 1'b1;
    addr = 16'h0000;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_fields();
    t_sync();
    t_unmapped();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
